/* pkg/adc_ctrl_pkg.sv */
// Purpose: Shared types and constants of the converter control block.
// Assumes: 20 MHz system clock; 10-bit result codes.
// Notes:   Times are kept in their own units; cycle counts derive from them.

package adc_ctrl_pkg;

   // ****************************************************************
   // Code widths and values
   // ****************************************************************
   localparam int          CODE_W      = 10;
   localparam logic [9:0]  CODE_MAX    = 10'h3FF;
   localparam logic [9:0]  CODE_ZERO   = 10'h000;
   localparam logic [9:0]  CODE_ONE    = 10'h001;
   localparam logic [9:0]  SIGN_FLIP   = 10'h200;
   localparam logic [10:0] MID_CODE    = 11'h200;
   localparam logic [10:0] OFFSET_ZERO = 11'h000;

   // ****************************************************************
   // Calibration field encodings
   // ****************************************************************
   localparam logic [1:0]  CAL_NORMAL   = 2'h0;
   localparam logic [1:0]  CAL_SYSTEM   = 2'h1;
   localparam logic [1:0]  CAL_INTERNAL = 2'h2;
   localparam logic [1:0]  CAL_IDLE     = 2'h3;

   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int CLOCK_PS        = 50000;
   localparam int OSC_PERIOD_PS   = 125000;
   localparam int POWERDOWN_NS    = 200;
   localparam int WAKE_NS         = 1000;
   // Longest time: rounds down, never below one cycle.
   localparam int OSC_START_CYC   = (OSC_PERIOD_PS / 2) / CLOCK_PS < 1 ? 1 : (OSC_PERIOD_PS / 2) / CLOCK_PS;
   // Least times: round up.
   localparam int POWERDOWN_CYC   = (POWERDOWN_NS * 1000 + CLOCK_PS - 1) / CLOCK_PS;
   localparam int WAKE_CYC        = (WAKE_NS * 1000 + CLOCK_PS - 1) / CLOCK_PS;

   // ****************************************************************
   // Pin index in the synchroniser vector
   // ****************************************************************
   localparam int PIN_RD    = 0;
   localparam int PIN_WR    = 1;
   localparam int PIN_CS    = 2;
   localparam int PIN_START = 3;
   localparam int PIN_COUNT = 4;
   localparam logic [3:0] PIN_IDLE = 4'hF;

   typedef struct packed {
      logic       clock_source_select;
      logic       code_format_select;
      logic       soft_powerdown_bit;
      logic [1:0] calibration_mode_field;
      logic       differential_mode;
      logic       auto_powerdown_enable;
      logic [1:0] conversion_mode;
   } cfg_t;

   localparam cfg_t CFG_RESET = '{clock_source_select: 1'b0, code_format_select: 1'b0,
                                  soft_powerdown_bit: 1'b0, calibration_mode_field: CAL_IDLE,
                                  differential_mode: 1'b0, auto_powerdown_enable: 1'b0,
                                  conversion_mode: 2'h0};

   typedef enum logic [2:0] {
      ST_IDLE    = 3'h1,
      ST_CONVERT = 3'h2,
      ST_DONE    = 3'h4
   } phase_t;

   typedef struct packed {
      phase_t       phase;
      cfg_t         cfg;
      logic         osc_run;
      logic         analog_on;
      logic         analog_powered;
      logic         sleep;
      logic         pd_armed;
      logic [4:0]   pd_count;
      logic [4:0]   wake_count;
      logic         ready;
      logic         trig_start;
      logic         cal_shot;
      logic         cal_taken;
      logic [10:0]  offset;
      logic [9:0]   result;
      logic         result_valid;
      logic         done_n;
      logic         request;
      logic         osc_enable;
      logic         midpoint;
      logic         cal_flag;
   } state_t;

endpackage : adc_ctrl_pkg

/* design/pin_sync.sv */
// Purpose: Three-stage synchroniser with agreement filter for host pins.
// Assumes: Pins are asynchronous to clock.
// Notes:   A level change is taken only when stages two and three agree.
`timescale 1ns/1ps

module pin_sync #(
   parameter int          WIDTH = 4,
   parameter logic [3:0]  IDLE  = 4'hF
) (
   input  wire logic             clock,
   input  wire logic             nrst,
   input  wire logic             enable,
   input  wire logic [WIDTH-1:0] pins,
   output logic      [WIDTH-1:0] level,
   output logic      [WIDTH-1:0] fall,
   output logic      [WIDTH-1:0] rise
);

   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;
   logic [WIDTH-1:0] stage3;
   logic [WIDTH-1:0] agreed;

   // Where stages disagree the old level is kept, so a one-cycle glitch is never seen.
   assign agreed = (stage2 == stage3) ? stage3 : level;

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         stage1 <= IDLE[WIDTH-1:0];
         stage2 <= IDLE[WIDTH-1:0];
         stage3 <= IDLE[WIDTH-1:0];
         level  <= IDLE[WIDTH-1:0];
         fall   <= '0;
         rise   <= '0;
      end else if (enable) begin
         stage1 <= pins;
         stage2 <= stage1;
         stage3 <= stage2;
         level  <= agreed;
         fall   <= level & ~agreed;
         rise   <= ~level & agreed;
      end
   end

endmodule : pin_sync

/* design/code_formatter.sv */
// Purpose: Offset correction, clamping and output code format.
// Assumes: Raw code is straight binary, 0 at the low reference.
// Notes:   Purely combinational; the caller registers the result.
`timescale 1ns/1ps

module code_formatter (
   input  wire logic [9:0]  raw_code,
   input  wire logic [10:0] offset,
   input  wire logic        apply_offset,
   input  wire logic        twos_complement,
   output logic      [9:0]  code
);

   logic signed [11:0] corrected;
   logic [9:0]         clamped;
   logic [9:0]         floor_code;
   logic               offset_positive;

   always_comb begin
      offset_positive = apply_offset && !offset[10] && (offset != adc_ctrl_pkg::OFFSET_ZERO);
      // A positive offset leaves code 0 unreachable, so the floor becomes 1.
      floor_code = offset_positive ? adc_ctrl_pkg::CODE_ONE : adc_ctrl_pkg::CODE_ZERO;
      corrected  = $signed({2'b00, raw_code}) - (apply_offset ? $signed({offset[10], offset}) : 12'sh000);
      if (corrected < $signed({2'b00, floor_code})) begin
         clamped = floor_code;
      end else if (corrected > $signed({2'b00, adc_ctrl_pkg::CODE_MAX})) begin
         clamped = adc_ctrl_pkg::CODE_MAX;
      end else begin
         clamped = corrected[9:0];
      end
      // Flipping the top bit turns offset binary into twos complement.
      code = twos_complement ? (clamped ^ adc_ctrl_pkg::SIGN_FLIP) : clamped;
   end

endmodule : code_formatter

/* design/adc_clock_power_calibration_ctrl.sv */
// Purpose: Conversion clock choice, power-down sequencing, offset calibration and code format.
// Assumes: Host pins arrive asynchronously; the analog section reports raw codes on clock.
// Notes:   Configuration is latched at the write strobe rising edge with chip select low.
`timescale 1ns/1ps

module adc_clock_power_calibration_ctrl (
   input  wire logic               clock,
   input  wire logic               nrst,
   input  wire logic               enable,
   input  wire logic               rd_n,
   input  wire logic               wr_n,
   input  wire logic               cs_n,
   input  wire logic               convert_start_n,
   input  wire adc_ctrl_pkg::cfg_t config_in,
   input  wire logic [9:0]         raw_code,
   input  wire logic               raw_valid,
   output logic                    oscillator_enable,
   output logic                    conversion_clock_run,
   output logic                    conversion_clock_external,
   output logic                    analog_powered,
   output logic                    reference_powered,
   output logic                    wake_ready,
   output logic                    conversion_request,
   output logic                    midpoint_connect,
   output logic                    calibrating,
   output logic [9:0]              result_code,
   output logic                    result_valid,
   output logic                    done_n
);

   // ****************************************************************
   // Pin synchronisers and formatter
   // ****************************************************************
   logic [adc_ctrl_pkg::PIN_COUNT-1:0] pin_level;
   logic [adc_ctrl_pkg::PIN_COUNT-1:0] pin_fall;
   logic [adc_ctrl_pkg::PIN_COUNT-1:0] pin_rise;
   logic [9:0]                         formatted;
   adc_ctrl_pkg::state_t               s;
   adc_ctrl_pkg::state_t               next_s;
   logic                               cal_active;
   logic                               interrupt_mode;

   pin_sync #(
      .WIDTH (adc_ctrl_pkg::PIN_COUNT),
      .IDLE  (adc_ctrl_pkg::PIN_IDLE)
   ) u_pin_sync (
      .clock  (clock),
      .nrst   (nrst),
      .enable (enable),
      .pins   ({convert_start_n, cs_n, wr_n, rd_n}),
      .level  (pin_level),
      .fall   (pin_fall),
      .rise   (pin_rise)
   );

   function automatic logic is_calibrating(input logic [1:0] field);
      is_calibrating = (field == adc_ctrl_pkg::CAL_SYSTEM) || (field == adc_ctrl_pkg::CAL_INTERNAL);
   endfunction : is_calibrating

   assign cal_active     = is_calibrating(s.cfg.calibration_mode_field);
   assign interrupt_mode = !s.cfg.conversion_mode[1];

   code_formatter u_code_formatter (
      .raw_code        (raw_code),
      .offset          (s.offset),
      .apply_offset    (!cal_active),
      .twos_complement (s.cfg.code_format_select),
      .code            (formatted)
   );

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb begin
      next_s              = s;
      next_s.request      = 1'b0;
      next_s.result_valid = 1'b0;
      // Configuration is touched only by a write, never by power-down.
      if (pin_rise[adc_ctrl_pkg::PIN_WR] && !pin_level[adc_ctrl_pkg::PIN_CS]) begin
         next_s.cfg = config_in;
         if (is_calibrating(config_in.calibration_mode_field) && !cal_active) begin
            next_s.cal_taken = 1'b0;
         end
         if (config_in.soft_powerdown_bit) begin
            next_s.pd_armed = 1'b1;
         end else begin
            next_s.pd_armed = 1'b0;
            if (s.sleep) begin
               next_s.sleep      = 1'b0;
               next_s.wake_count = 5'(adc_ctrl_pkg::WAKE_CYC);
            end
         end
      end
      // The count starts at the synchronised chip select rise, so pin latency adds to the delay.
      if (s.pd_armed && pin_rise[adc_ctrl_pkg::PIN_CS]) begin
         next_s.pd_count = 5'(adc_ctrl_pkg::POWERDOWN_CYC);
      end else if (s.pd_count != 5'h00) begin
         next_s.pd_count = s.pd_count - 5'h01;
         if (s.pd_count == 5'h01 && s.pd_armed) begin
            next_s.sleep    = 1'b1;
            next_s.pd_armed = 1'b0;
         end
      end
      // Triggers are not held off during the wake delay; the host has to wait for it.
      if (s.wake_count != 5'h00) begin
         next_s.wake_count = s.wake_count - 5'h01;
      end
      // Resume from auto power-down on the edge that matches the last trigger.
      if (!s.analog_on && ((pin_fall[adc_ctrl_pkg::PIN_CS] && !s.trig_start) ||
                           (pin_fall[adc_ctrl_pkg::PIN_START] && s.trig_start))) begin
         next_s.analog_on = 1'b1;
      end
      case (s.phase)
         adc_ctrl_pkg::ST_IDLE: begin
            if (!s.sleep && (pin_fall[adc_ctrl_pkg::PIN_RD] || pin_fall[adc_ctrl_pkg::PIN_START])) begin
               next_s.phase      = adc_ctrl_pkg::ST_CONVERT;
               next_s.request    = 1'b1;
               next_s.osc_run    = !s.cfg.clock_source_select;
               next_s.trig_start = !pin_fall[adc_ctrl_pkg::PIN_RD];
               next_s.cal_shot   = cal_active && pin_fall[adc_ctrl_pkg::PIN_RD];
            end
         end
         adc_ctrl_pkg::ST_CONVERT: begin
            if (raw_valid) begin
               next_s.osc_run      = 1'b0;
               next_s.result       = formatted;
               next_s.result_valid = 1'b1;
               if (s.cal_shot && !s.cal_taken) begin
                  next_s.offset    = {1'b0, raw_code} - adc_ctrl_pkg::MID_CODE;
                  next_s.cal_taken = 1'b1;
               end
               if (interrupt_mode) begin
                  next_s.phase  = adc_ctrl_pkg::ST_DONE;
                  next_s.done_n = 1'b0;
                  if (s.cfg.auto_powerdown_enable) begin
                     next_s.analog_on = 1'b0;
                  end
               end else begin
                  next_s.phase = adc_ctrl_pkg::ST_IDLE;
               end
            end
         end
         adc_ctrl_pkg::ST_DONE: begin
            // A start-triggered result is released by the read fall, a read-triggered one by the read rise.
            if ((s.trig_start && pin_fall[adc_ctrl_pkg::PIN_RD]) || pin_rise[adc_ctrl_pkg::PIN_RD]) begin
               next_s.done_n = 1'b1;
               next_s.phase  = adc_ctrl_pkg::ST_IDLE;
            end
         end
         default: begin
            next_s.phase  = adc_ctrl_pkg::ST_IDLE;
            next_s.done_n = 1'b1;
         end
      endcase
      if (next_s.sleep) begin
         next_s.osc_run = 1'b0;
      end
      next_s.analog_powered = next_s.analog_on && !next_s.sleep;
      next_s.ready          = !next_s.sleep && (next_s.wake_count == 5'h00);
      // Pin-facing flags are registered here; only reference_powered is an inverter away from a flop.
      next_s.osc_enable     = !next_s.cfg.clock_source_select && !next_s.sleep;
      next_s.midpoint       = next_s.cfg.calibration_mode_field == adc_ctrl_pkg::CAL_INTERNAL;
      next_s.cal_flag       = is_calibrating(next_s.cfg.calibration_mode_field);
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         s <= '{phase: adc_ctrl_pkg::ST_IDLE, cfg: adc_ctrl_pkg::CFG_RESET, osc_run: 1'b0,
                analog_on: 1'b1, analog_powered: 1'b1, sleep: 1'b0, pd_armed: 1'b0,
                pd_count: 5'h00, wake_count: 5'h00, ready: 1'b1, trig_start: 1'b0,
                cal_shot: 1'b0, cal_taken: 1'b0, offset: adc_ctrl_pkg::OFFSET_ZERO,
                result: 10'h000, result_valid: 1'b0, done_n: 1'b1, request: 1'b0,
                osc_enable: 1'b1, midpoint: 1'b0, cal_flag: 1'b0};
      end else if (enable) begin
         s <= next_s;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   // Every output but reference_powered, the inverse of s.sleep, is a state bit.
   assign oscillator_enable         = s.osc_enable;
   assign conversion_clock_run      = s.osc_run;
   assign conversion_clock_external = s.cfg.clock_source_select;
   assign analog_powered            = s.analog_powered;
   assign reference_powered         = !s.sleep;
   assign wake_ready                = s.ready;
   assign conversion_request        = s.request;
   assign midpoint_connect          = s.midpoint;
   assign calibrating               = s.cal_flag;
   assign result_code               = s.result;
   assign result_valid              = s.result_valid;
   assign done_n                    = s.done_n;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   // The wake check spends eight cycles in a repetition and the rest in a delay.
   localparam int WAKE_REST = adc_ctrl_pkg::WAKE_CYC - 8;
   localparam int OSC_DLY  = adc_ctrl_pkg::OSC_START_CYC;

   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst || !enable);

   sequence cs_rise_armed_s;
      s.pd_armed && pin_rise[adc_ctrl_pkg::PIN_CS] && !pin_rise[adc_ctrl_pkg::PIN_WR];
   endsequence
   // Power-down stays armed through the whole count; a write clearing soft_powerdown_bit before the last count cycle cancels it.
   sequence armed_wait_s;
      s.pd_armed [*4];
   endsequence

   ext_osc_off_a: assert property (conversion_clock_external |-> !oscillator_enable)
      else $error("oscillator runs with external clock selected");
   osc_start_a: assert property (s.phase == adc_ctrl_pkg::ST_IDLE && !s.sleep && !s.cfg.clock_source_select &&
                                 pin_fall[adc_ctrl_pkg::PIN_RD] |-> ##OSC_DLY conversion_clock_run)
      else $error("internal clock late after trigger");
   done_low_a: assert property (s.phase == adc_ctrl_pkg::ST_CONVERT && raw_valid && interrupt_mode
                                |=> !done_n && result_valid)
      else $error("done not asserted when data ready");
   sleep_entry_a: assert property (cs_rise_armed_s ##1 armed_wait_s |-> !s.sleep ##1 s.sleep)
      else $error("software power-down not entered on time");
   wake_delay_a: assert property ($fell(s.sleep) |-> !wake_ready [*8] ##WAKE_REST !wake_ready
                                  ##1 wake_ready)
      else $error("wake ready timing wrong");
   cal_store_a: assert property (s.phase == adc_ctrl_pkg::ST_CONVERT && raw_valid && s.cal_shot && !s.cal_taken
                                 |=> s.offset == ({1'b0, $past(raw_code)} - adc_ctrl_pkg::MID_CODE))
      else $error("calibration offset not stored");
   cal_raw_a: assert property (s.phase == adc_ctrl_pkg::ST_CONVERT && raw_valid && cal_active &&
                               !s.cfg.code_format_select |=> result_code == $past(raw_code))
      else $error("offset applied during calibration");
   auto_pd_a: assert property (s.phase == adc_ctrl_pkg::ST_CONVERT && raw_valid && interrupt_mode &&
                               s.cfg.auto_powerdown_enable |=> $fell(done_n) && !analog_powered && reference_powered)
      else $error("auto power-down not taken at done");
   cont_mode_a: assert property (s.cfg.conversion_mode[1] && s.analog_on && !s.sleep |=> analog_powered)
      else $error("auto power-down in continuous mode");
   clock_sel_a: assert property (pin_rise[adc_ctrl_pkg::PIN_WR] && !pin_level[adc_ctrl_pkg::PIN_CS]
                                 |=> conversion_clock_external == $past(config_in.clock_source_select))
      else $error("clock source not changed at write rise");

   // Reset, triggers and done release.
   reset_offset_a: assert property ($rose(nrst) |-> s.offset == adc_ctrl_pkg::OFFSET_ZERO)
      else $error("stored offset not cleared by reset");
   rd_trigger_a: assert property (s.phase == adc_ctrl_pkg::ST_IDLE && !s.sleep && pin_fall[adc_ctrl_pkg::PIN_RD]
                                  |=> conversion_request && s.phase == adc_ctrl_pkg::ST_CONVERT)
      else $error("read fall did not start a conversion");
   start_osc_a: assert property (s.phase == adc_ctrl_pkg::ST_IDLE && !s.sleep && !s.cfg.clock_source_select &&
                                 pin_fall[adc_ctrl_pkg::PIN_START] |-> ##OSC_DLY conversion_clock_run)
      else $error("internal clock late after convert start");
   done_release_a: assert property (s.phase == adc_ctrl_pkg::ST_DONE && pin_rise[adc_ctrl_pkg::PIN_RD] |=> done_n)
      else $error("done not released by read rise");

   // Power-down.
   cfg_hold_a: assert property (s.sleep && !pin_rise[adc_ctrl_pkg::PIN_WR] |=> $stable(s.cfg))
      else $error("configuration changed in power-down");
   sleep_block_a: assert property (s.sleep |=> !conversion_request)
      else $error("conversion started in power-down");
   resume_cs_a: assert property (s.phase == adc_ctrl_pkg::ST_IDLE && !s.analog_on && !s.sleep && !s.trig_start &&
                                 pin_fall[adc_ctrl_pkg::PIN_CS] |=> analog_powered)
      else $error("analog section not resumed at chip select fall");

   // Calibration field.
   midpoint_sel_a: assert property (pin_rise[adc_ctrl_pkg::PIN_WR] && !pin_level[adc_ctrl_pkg::PIN_CS] &&
                                    config_in.calibration_mode_field == adc_ctrl_pkg::CAL_INTERNAL
                                    |=> midpoint_connect && calibrating)
      else $error("internal calibration not entered");
   normal_return_a: assert property (pin_rise[adc_ctrl_pkg::PIN_WR] && !pin_level[adc_ctrl_pkg::PIN_CS] &&
                                     config_in.calibration_mode_field == adc_ctrl_pkg::CAL_NORMAL
                                     |=> !calibrating && !midpoint_connect)
      else $error("normal conversion not resumed");

endmodule : adc_clock_power_calibration_ctrl

/* dv/analog_model.sv */
// Purpose: Analog section stand-in that answers conversion requests.
// Assumes: Same clock as the control block.
// Notes:   The code is valid only with its one-cycle valid pulse.
`timescale 1ns/1ps

module analog_model #(
   parameter int DELAY = 6
) (
   input  wire logic       clock,
   input  wire logic       nrst,
   input  wire logic       conversion_request,
   input  wire logic [9:0] level,
   output logic      [9:0] raw_code,
   output logic            raw_valid
);
   int cnt;

   // The code toggles outside the valid pulse so stale data is never taken for a result.
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         cnt <= 0;
         raw_valid <= 1'b0;
         raw_code <= 10'h000;
      end else begin
         raw_valid <= 1'b0;
         raw_code <= ~raw_code;
         if (conversion_request) begin
            cnt <= DELAY;
         end else if (cnt == 1) begin
            cnt <= 0;
            raw_valid <= 1'b1;
            raw_code <= level;
         end else if (cnt > 1) begin
            cnt <= cnt - 1;
         end
      end
   end
endmodule : analog_model

/* dv/test_adc_clock_power_calibration_ctrl.sv */
// Purpose: Self-checking bench of the converter control block.
// Assumes: Host pins driven at the falling clock edge.
// Notes:   Expected codes are worked out by hand from raw codes and offset.
`timescale 1ns/1ps

module test_adc_clock_power_calibration_ctrl;
   logic clock = 1'b0, nrst = 1'b0, enable = 1'b1;
   logic rd_n = 1'b1, wr_n = 1'b1, cs_n = 1'b1, convert_start_n = 1'b1;
   adc_ctrl_pkg::cfg_t config_in = adc_ctrl_pkg::CFG_RESET;
   adc_ctrl_pkg::cfg_t c;
   logic [9:0] raw_code, level = 10'h000, result_code;
   logic raw_valid, oscillator_enable, conversion_clock_run, conversion_clock_external;
   logic analog_powered, reference_powered, wake_ready, conversion_request;
   logic midpoint_connect, calibrating, result_valid, done_n, pd;
   int n_fail = 0, check_count = 0, cycles = 0;

   adc_clock_power_calibration_ctrl u_adc_clock_power_calibration_ctrl (.clock(clock), .nrst(nrst),
      .enable(enable), .rd_n(rd_n), .wr_n(wr_n), .cs_n(cs_n), .convert_start_n(convert_start_n),
      .config_in(config_in), .raw_code(raw_code), .raw_valid(raw_valid),
      .oscillator_enable(oscillator_enable), .conversion_clock_run(conversion_clock_run),
      .conversion_clock_external(conversion_clock_external), .analog_powered(analog_powered),
      .reference_powered(reference_powered), .wake_ready(wake_ready),
      .conversion_request(conversion_request), .midpoint_connect(midpoint_connect),
      .calibrating(calibrating), .result_code(result_code), .result_valid(result_valid), .done_n(done_n));
   analog_model u_analog_model (.clock(clock), .nrst(nrst), .conversion_request(conversion_request),
      .level(level), .raw_code(raw_code), .raw_valid(raw_valid));

   always #25 clock = ~clock;

   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         n_fail++;
         give_verdict();
      end
   end

   task give_verdict();
      $display("checks %0d failures %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : give_verdict

   task chk(input string n, input logic [9:0] e, input logic [9:0] g);
      check_count++;
      if (g !== e) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   task wr(input adc_ctrl_pkg::cfg_t v);
      @(negedge clock);
      cs_n = 1'b0;
      config_in = v;
      wr_n = 1'b0;
      repeat (6) @(negedge clock);
      wr_n = 1'b1;
      repeat (8) @(negedge clock);
   endtask : wr

   task conv(input logic [9:0] raw, input logic st, input logic [9:0] e);
      logic run;
      logic req;
      run = 1'b0;
      req = 1'b0;
      level = raw;
      @(negedge clock);
      if (st) convert_start_n = 1'b0;
      else rd_n = 1'b0;
      for (int i = 0; i < 40 && result_valid !== 1'b1; i++) begin
         @(negedge clock);
         run |= conversion_clock_run;
         req |= conversion_request;
      end
      chk("result", e, result_code);
      chk("done low", 10'h000, {9'h000, done_n});
      chk("clock ran", 10'h001, {9'h000, run});
      chk("request", 10'h001, {9'h000, req});
      pd = analog_powered;
      if (st) begin
         convert_start_n = 1'b1;
         repeat (6) @(negedge clock);
         rd_n = 1'b0;
         repeat (6) @(negedge clock);
      end
      rd_n = 1'b1;
      repeat (8) @(negedge clock);
      chk("done released", 10'h001, {9'h000, done_n});
   endtask : conv

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      repeat (8) @(negedge clock);
      nrst = 1'b1;
      chk("osc on", 10'h001, {9'h000, oscillator_enable});
      chk("calibrating", 10'h000, {9'h000, calibrating});
      c = adc_ctrl_pkg::CFG_RESET;
      c.clock_source_select = 1'b1;
      wr(c);
      chk("external", 10'h001, {9'h000, conversion_clock_external});
      chk("osc off", 10'h000, {9'h000, oscillator_enable});
      c.clock_source_select = 1'b0;
      wr(c);
      chk("internal", 10'h000, {9'h000, conversion_clock_external});
      conv(10'h123, 1'b0, 10'h123);
      conv(10'h0AB, 1'b1, 10'h0AB);
      c.calibration_mode_field = adc_ctrl_pkg::CAL_INTERNAL;
      wr(c);
      chk("midpoint", 10'h001, {9'h000, midpoint_connect});
      conv(10'h214, 1'b0, 10'h214);
      c.calibration_mode_field = adc_ctrl_pkg::CAL_SYSTEM;
      wr(c);
      chk("system cal", 10'h002, {8'h00, calibrating, midpoint_connect});
      c.calibration_mode_field = adc_ctrl_pkg::CAL_NORMAL;
      wr(c);
      chk("normal", 10'h000, {9'h000, calibrating});
      conv(10'h300, 1'b0, 10'h2EC);
      conv(10'h005, 1'b0, 10'h001);
      conv(10'h3FF, 1'b0, 10'h3EB);
      c.calibration_mode_field = adc_ctrl_pkg::CAL_IDLE;
      c.code_format_select = 1'b1;
      c.soft_powerdown_bit = 1'b1;
      wr(c);
      cs_n = 1'b1;
      repeat (3) @(negedge clock);
      chk("not yet asleep", 10'h001, {9'h000, reference_powered});
      repeat (6) @(negedge clock);
      chk("asleep", 10'h000, {8'h00, reference_powered, analog_powered});
      c.soft_powerdown_bit = 1'b0;
      wr(c);
      chk("waking", 10'h000, {9'h000, wake_ready});
      for (int i = 0; i < 40 && wake_ready !== 1'b1; i++) @(negedge clock);
      chk("awake", 10'h001, {9'h000, wake_ready});
      conv(10'h300, 1'b0, 10'h0EC);
      c.auto_powerdown_enable = 1'b1;
      wr(c);
      conv(10'h300, 1'b0, 10'h0EC);
      chk("auto down", 10'h000, {9'h000, pd});
      cs_n = 1'b1;
      repeat (8) @(negedge clock);
      cs_n = 1'b0;
      repeat (8) @(negedge clock);
      chk("resumed", 10'h001, {9'h000, analog_powered});
      conv(10'h300, 1'b0, 10'h0EC);
      chk("auto down again", 10'h000, {9'h000, pd});
      cs_n = 1'b1;
      repeat (8) @(negedge clock);
      c.conversion_mode = 2'h2;
      wr(c);
      level = 10'h300;
      rd_n = 1'b0;
      for (int i = 0; i < 40 && result_valid !== 1'b1; i++) @(negedge clock);
      chk("continuous result", 10'h0EC, result_code);
      chk("continuous done", 10'h001, {9'h000, done_n});
      chk("continuous power", 10'h001, {9'h000, analog_powered});
      rd_n = 1'b1;
      repeat (8) @(negedge clock);
      c.conversion_mode = 2'h0;
      c.auto_powerdown_enable = 1'b0;
      c.differential_mode = 1'b1;
      c.calibration_mode_field = adc_ctrl_pkg::CAL_INTERNAL;
      wr(c);
      conv(10'h1F0, 1'b0, 10'h3F0);
      c.calibration_mode_field = adc_ctrl_pkg::CAL_NORMAL;
      wr(c);
      conv(10'h3F8, 1'b0, 10'h1FF);
      conv(10'h000, 1'b0, 10'h210);
      enable = 1'b0;
      rd_n = 1'b0;
      repeat (10) @(negedge clock);
      chk("frozen", 10'h000, {8'h00, conversion_clock_run, conversion_request});
      enable = 1'b1;
      rd_n = 1'b1;
      repeat (8) @(negedge clock);
      give_verdict();
   end
endmodule : test_adc_clock_power_calibration_ctrl
